/* File: hw/btm_monitor.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Fault line driven open-collector only
// - Cycle ends on fault; exception in the same cycle as release
// - Six-bit counter cleared while strobe negated
// - Count 4 MHz ticks, fault on overflow
// - Extended variant times out at 5.5 us
// - Time strobe width, not the acknowledge
// - Latch first timed-out probe address as memory base
// - Page fault asserts fault only while acknowledge is negated
module btm_monitor
   import btm_pkg::*;
#(
   parameter bit EXTENDED = 1'b0,
   parameter int unsigned AW = ADDR_WIDTH
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   input wire logic clk_en,
   // Bus side, active-low strobe and fault
   input wire logic buffered_addr_strobe_n,
   input wire logic transfer_acknowledge_n,
   input wire logic [AW-1:0] bus_addr,
   input wire logic bus_fault_line_n_in,
   output logic bus_fault_line_oe,
   output logic bus_fault_line_out,
   // Processor side
   input wire logic page_fault,
   input wire logic probe_active,
   output logic cycle_abort,
   output logic fault_exception,
   output logic [AW-1:0] mem_base,
   output logic mem_base_valid
);
   // ***********************************************
   // Timeout counter
   // ***********************************************
   localparam int unsigned LIMIT = EXTENDED ? EXT_TICKS : BASE_TICKS;
   localparam logic [5:0] LIMIT_M1 = 6'(LIMIT - 1);

   btm_state_e state_q, state_d;
   logic [5:0] cnt_q, cnt_d;
   logic tick;
   logic strobe;
   logic line_low_q, line_low_d;
   logic abort_q, abort_d;
   logic exc_q, exc_d;
   logic [AW-1:0] base_q, base_d;
   logic base_v_q, base_v_d;

   assign strobe = !buffered_addr_strobe_n;

   btm_tick_gen u_tick (
      .clock(clock),
      .reset(reset),
      .clk_en(clk_en),
      .run(strobe && state_q == BTM_TIMING),
      .tick(tick)
   );

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      line_low_d = line_low_q;
      abort_d = 1'b0;
      exc_d = 1'b0;
      base_d = base_q;
      base_v_d = base_v_q;
      case (state_q)
         BTM_IDLE: begin
            cnt_d = 6'h00;
            if (strobe) begin
               state_d = BTM_TIMING;
            end
         end
         BTM_TIMING: begin
            if (!strobe) begin
               // Acknowledge only ends the strobe
               state_d = BTM_IDLE;
               cnt_d = 6'h00;
            end else if (page_fault && transfer_acknowledge_n) begin
               state_d = BTM_FAULT;
               line_low_d = 1'b1;
               abort_d = 1'b1;
            end else if (tick && cnt_q == LIMIT_M1) begin
               // Overflow
               state_d = BTM_FAULT;
               line_low_d = 1'b1;
               abort_d = 1'b1;
               if (probe_active && !base_v_q) begin
                  base_d = bus_addr;
                  base_v_d = 1'b1;
               end
            end else if (tick) begin
               cnt_d = cnt_q + 6'h01;
            end
         end
         BTM_FAULT: begin
            // Hold until strobe drops
            if (!strobe) begin
               state_d = BTM_IDLE;
               cnt_d = 6'h00;
               line_low_d = 1'b0;
               exc_d = 1'b1;
            end
         end
         default: begin
            state_d = BTM_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state_q <= BTM_IDLE;
         cnt_q <= 6'h00;
         line_low_q <= 1'b0;
         abort_q <= 1'b0;
         exc_q <= 1'b0;
         base_q <= LOCATE_RESET[AW-1:0];
         base_v_q <= 1'b0;
      end else if (clk_en) begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         line_low_q <= line_low_d;
         abort_q <= abort_d;
         exc_q <= exc_d;
         base_q <= base_d;
         base_v_q <= base_v_d;
      end
   end

   // Open-collector: only ever pulls low, never drives high
   assign bus_fault_line_oe = line_low_q;
   assign bus_fault_line_out = 1'b0;
   assign cycle_abort = abort_q;
   assign fault_exception = exc_q;
   assign mem_base = base_q;
   assign mem_base_valid = base_v_q;

   // ***********************************************
   // Checks
   // ***********************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   sequence strobe_drop_s;
      clk_en && state_q == BTM_FAULT && !strobe;
   endsequence

   counter_clear_a: assert property (
      clk_en && !strobe |=> cnt_q == 6'h00)
      else $error("Counter not cleared with strobe idle");
   no_early_fault_a: assert property (
      !line_low_q && line_low_d && !page_fault |->
      cnt_q == LIMIT_M1 && tick)
      else $error("Fault asserted before overflow");
   fault_hold_a: assert property (
      line_low_q && strobe |=> line_low_q)
      else $error("Fault released while strobe held");
   fault_release_a: assert property (
      strobe_drop_s |=> !line_low_q ##0 exc_q)
      else $error("Fault not released with exception");
   oc_drive_a: assert property (
      bus_fault_line_out == 1'b0)
      else $error("Fault line driven high");
   abort_pulse_a: assert property (
      $rose(line_low_q) |-> abort_q)
      else $error("No cycle abort with fault");
   page_fault_a: assert property (
      clk_en && state_q == BTM_TIMING && strobe && page_fault &&
      transfer_acknowledge_n |=> line_low_q)
      else $error("Page fault did not raise fault");
   base_latch_a: assert property (
      $rose(base_v_q) |-> base_q == $past(bus_addr))
      else $error("Probe address not latched");

   // Any agent may pull the line; our pull must show on it
   line_wired_a: assert property (
      line_low_q |-> !bus_fault_line_n_in)
      else $error("Fault line not low while pulled");

   abort_once_a: assert property (
      clk_en && abort_q |=> !abort_q)
      else $error("Cycle abort longer than one cycle");

   exc_once_a: assert property (
      clk_en && exc_q |=> !exc_q)
      else $error("Exception pulse longer than one cycle");

   exc_after_a: assert property (
      exc_q |-> !line_low_q)
      else $error("Exception while fault still pulled");

   base_sticky_a: assert property (
      base_v_q |=> base_v_q && $stable(base_q))
      else $error("Memory base changed after latch");

   timing_start_a: assert property (
      clk_en && state_q == BTM_IDLE && strobe |=>
      state_q == BTM_TIMING && cnt_q == 6'h00)
      else $error("Timing did not restart from zero");

   // While strobe is held, only a tick may move the count
   count_step_a: assert property (
      clk_en && state_q == BTM_TIMING && strobe && !tick |=>
      $stable(cnt_q))
      else $error("Counter moved without a tick");

   overflow_fault_a: assert property (
      clk_en && state_q == BTM_TIMING && strobe && tick &&
      cnt_q == LIMIT_M1 |=> line_low_q)
      else $error("No fault at counter overflow");

   // Low enable must freeze the whole timer
   freeze_hold_a: assert property (
      !clk_en |=> $stable(cnt_q) && $stable(line_low_q) &&
      $stable(state_q))
      else $error("State moved while clock enable low");
endmodule

/* File: hw/btm_pkg.sv */
package btm_pkg;
   // Timing in nanoseconds and clock rate
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned TICK_PERIOD_NS = 250;
   localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned BASE_TIMEOUT_NS = 4000;
   localparam int unsigned EXT_TIMEOUT_NS = 5600;
   // Counter ticks to overflow, per variant
   localparam int unsigned CNT_WIDTH = 4;
   localparam int unsigned BASE_TICKS = BASE_TIMEOUT_NS / TICK_PERIOD_NS;
   localparam int unsigned EXT_TICKS = EXT_TIMEOUT_NS / TICK_PERIOD_NS;
   localparam int unsigned ADDR_WIDTH = 24;
   localparam logic [23:0] LOCATE_RESET = 24'h000000;
   typedef enum logic [1:0] {
      BTM_IDLE,
      BTM_TIMING,
      BTM_FAULT
   } btm_state_e;
endpackage

/* File: hw/btm_tick_gen.sv */
`timescale 1ns/1ps
// Divides the 20 MHz clock to a 4 MHz tick; restarts with each strobe
module btm_tick_gen
   import btm_pkg::*;
#(
   parameter int unsigned DIV = TICK_CYCLES
) (
   // Clock and control
   input wire logic clock,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic run,
   // Tick out
   output logic tick
);
   logic [2:0] div_q, div_d;
   logic tick_d, tick_q;

   always_comb begin
      div_d = div_q;
      tick_d = 1'b0;
      if (!run) begin
         div_d = 3'h0;
      end else if (div_q == 3'(DIV - 1)) begin
         div_d = 3'h0;
         tick_d = 1'b1;
      end else begin
         div_d = div_q + 3'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         div_q <= 3'h0;
         tick_q <= 1'b0;
      end else if (clk_en) begin
         div_q <= div_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q & run;
endmodule

/* File: sim/btm_bus_agent.sv */
`timescale 1ns/1ps
// ****************
// Master and slave model on the far side
// ****************
module btm_bus_agent (
   // Clock and request
   input wire logic clock,
   input wire logic go,
   input wire logic [7:0] ack_dly,
   input wire logic fault_n, // Observed only
   // Bus lines
   output logic strobe_n,
   output logic ack_n,
   output logic busy
);
   logic [7:0] cnt;
   initial begin
      strobe_n = 1'b1;
      ack_n = 1'b1;
      busy = 1'b0;
      cnt = 8'h00;
   end
   always @(posedge clock) begin
      if (go && !busy) begin
         busy <= 1'b1;
         strobe_n <= 1'b0;
         cnt <= 8'h00;
      end else if (busy) begin
         cnt <= cnt + 8'h01;
         // Get off the bus on ack or on fault
         if (!ack_n || !fault_n) begin
            strobe_n <= 1'b1;
            ack_n <= 1'b1;
            busy <= 1'b0;
         end else if (cnt == ack_dly) begin
            ack_n <= 1'b0;
         end
      end
   end
endmodule

/* File: sim/bus_timeout_error_monitor_tb.sv */
`timescale 1ns/1ps
module bus_timeout_error_monitor_tb;
   import btm_pkg::*;
   typedef struct {
      logic [7:0] dly;
      logic pb, pf, ex;
      logic [23:0] adr, mb;
      int lo, hi;
   } btm_row_s;
   logic clock, reset, go, probe, pf, oe, outv, ab, fx, mbv, fault_n;
   logic ce, oe_x, outv_x, ab_x, fx_x, mbv_x;
   logic [23:0] mb_x;
   logic [7:0] dly;
   logic [23:0] adr, mb;
   logic strobe_n, ack_n, busy;
   int n_mismatch, cmp_count, nab, nex, fk;
   btm_row_s rows[9];
   // Pull-up on the shared line, open-collector pull-downs
   assign fault_n = (oe | oe_x) ? 1'b0 : 1'b1;
   btm_bus_agent i_btm_bus_agent (.clock(clock), .go(go), .ack_dly(dly),
      .fault_n(fault_n), .strobe_n(strobe_n), .ack_n(ack_n), .busy(busy));
   btm_monitor #(.EXTENDED(1'b1)) i_btm_monitor_ext (.clock(clock),
      .reset(reset), .clk_en(1'b1), .buffered_addr_strobe_n(strobe_n),
      .transfer_acknowledge_n(ack_n), .bus_addr(adr),
      .bus_fault_line_n_in(fault_n), .bus_fault_line_oe(oe_x),
      .bus_fault_line_out(outv_x), .page_fault(pf), .probe_active(probe),
      .cycle_abort(ab_x), .fault_exception(fx_x), .mem_base(mb_x),
      .mem_base_valid(mbv_x));
   btm_monitor i_btm_monitor (.clock(clock), .reset(reset), .clk_en(ce),
      .buffered_addr_strobe_n(strobe_n), .transfer_acknowledge_n(ack_n),
      .bus_addr(adr), .bus_fault_line_n_in(fault_n),
      .bus_fault_line_oe(oe), .bus_fault_line_out(outv), .page_fault(pf),
      .probe_active(probe), .cycle_abort(ab), .fault_exception(fx),
      .mem_base(mb), .mem_base_valid(mbv));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("mismatches %0d of %0d compares", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic run(input btm_row_s r);
      dly <= r.dly; probe <= r.pb; pf <= r.pf; adr <= r.adr; go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      nab = 0; nex = 0; fk = -1;
      for (int k = 0; k < 200; k++) begin
         @(posedge clock);
         #1;
         if ((oe === 1'b1 || oe_x === 1'b1) && fk < 0) fk = k;
         nab += (ab === 1'b1 || ab_x === 1'b1);
         nex += (fx === 1'b1 || fx_x === 1'b1);
      end
      check(fk >= 0, r.ex);
      check(nab, r.ex);
      check(nex, r.ex);
      if (r.ex) check(fk >= r.lo && fk <= r.hi, 1);
      check(mb, r.mb);
   endtask
   initial begin
      #250000;
      n_mismatch++;
      give_verdict();
   end
   initial begin
      n_mismatch = 0; cmp_count = 0;
      reset = 1'b1; go = 1'b0; probe = 1'b0; pf = 1'b0; ce = 1'b1;
      dly = 8'h00; adr = 24'h000000;
      // Prompt, slow-but-legal, late, absent and page-fault cycles
      rows = '{'{8'h03, 0, 0, 0, 24'h1, 24'h0, 0, 0},
               '{8'h44, 0, 0, 0, 24'h2, 24'h0, 0, 0},
               '{8'h64, 0, 0, 1, 24'h3, 24'h0, 76, 84},
               '{8'hff, 1, 0, 1, 24'h3a0000, 24'h3a0000, 76, 84},
               '{8'hff, 1, 0, 1, 24'h5c0000, 24'h3a0000, 76, 84},
               '{8'hff, 0, 1, 1, 24'h4, 24'h3a0000, 0, 3},
               '{8'h02, 0, 0, 0, 24'h5, 24'h3a0000, 0, 0},
               '{8'h1d, 0, 0, 0, 24'h7, 24'h3a0000, 0, 0},
               '{8'h3a, 0, 0, 0, 24'h8, 24'h3a0000, 0, 0}};
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      #1;
      check({oe, ab, fx, mbv}, 0);
      check(mb, LOCATE_RESET);
      check(outv, 0);
      check(outv_x, 0);
      foreach (rows[i]) run(rows[i]);
      check(mbv, 1);
      // Base timer frozen: only the long variant may time out
      ce <= 1'b0;
      run('{8'hff, 0, 0, 1, 24'h6, 24'h3a0000, 106, 114});
      ce <= 1'b1;
      // Reset in mid-cycle: timing restarts from zero
      dly <= 8'hff; probe <= 1'b0; pf <= 1'b0; go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      repeat (40) @(posedge clock);
      reset <= 1'b1;
      @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      #1;
      check({oe, ab, fx, mbv}, 0);
      fk = -1;
      for (int k = 0; k < 100; k++) begin
         @(posedge clock);
         #1;
         if (oe === 1'b1 && fk < 0) fk = k;
      end
      check(fk >= 76 && fk <= 84, 1);
      give_verdict();
   end
endmodule
